// [verilog/ssd_pkg.sv]
// Shared constants, types and shift helpers for both ends of the serial link.
package ssd_pkg;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam int          DATA_W        = 16;
    localparam logic [3:0]  WIDTH_TOP_MIN = 4'h1;
    localparam logic [15:0] DATA_RESET    = 16'h0000;
    localparam logic [15:0] BAUD_ZERO     = 16'h0000;
    localparam logic [5:0]  STEP_RESET    = 6'h00;
    localparam logic [3:0]  BITS_RESET    = 4'h0;
    localparam logic [2:0]  SYNC_RESET    = 3'h7;
    localparam logic        LINE_IDLE     = 1'h1;

    typedef enum logic {ST_IDLE, ST_RUN} ssd_state_t;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Top bit index of a frame; codes below the minimum give 2-bit frames.
    function automatic logic [3:0] ssd_top(input logic [3:0] code);
        return (code < WIDTH_TOP_MIN) ? WIDTH_TOP_MIN : code;
    endfunction : ssd_top

    // Shift one received bit in; data stays right aligned for either order.
    function automatic logic [15:0] ssd_shift_in(input logic [15:0] sr, input logic b,
                                                 input logic msb, input logic [3:0] top);
        logic [15:0] r;
        r = sr;
        if (msb) begin
            r = {sr[14:0], b};
        end else begin
            r      = {1'h0, sr[15:1]};
            r[top] = b;
        end
        return r;
    endfunction : ssd_shift_in

    // Bit that goes out next from the shift register.
    function automatic logic ssd_out_bit(input logic [15:0] sr, input logic msb,
                                         input logic [3:0] top);
        return msb ? sr[top] : sr[0];
    endfunction : ssd_out_bit

endpackage : ssd_pkg

// [verilog/ssd_link_if.sv]
// Three-wire link between the unit and its peer, resolved as wired-AND with pull-up.
`timescale 1ns/10ps
`default_nettype none
interface ssd_link_if;
    logic dev_sclk_o;
    logic dev_sclk_oe;
    logic dev_mosi_o;
    logic dev_mosi_oe;
    logic dev_miso_o;
    logic dev_miso_oe;
    logic peer_sclk_o;
    logic peer_sclk_oe;
    logic peer_mosi_o;
    logic peer_mosi_oe;
    logic peer_miso_o;
    logic peer_miso_oe;
    logic sclk;
    logic mosi;
    logic miso;

    // An undriven line floats high through the pull-up.
    assign sclk = (~dev_sclk_oe | dev_sclk_o) & (~peer_sclk_oe | peer_sclk_o);
    assign mosi = (~dev_mosi_oe | dev_mosi_o) & (~peer_mosi_oe | peer_mosi_o);
    assign miso = (~dev_miso_oe | dev_miso_o) & (~peer_miso_oe | peer_miso_o);

    modport dev (output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
                 dev_miso_o, dev_miso_oe, input sclk, mosi, miso);
    modport peer (output peer_sclk_o, peer_sclk_oe, peer_mosi_o, peer_mosi_oe,
                  peer_miso_o, peer_miso_oe, input sclk, mosi, miso);
endinterface : ssd_link_if
`default_nettype wire

// [verilog/ssd_peer.sv]
// Slave-only partner controller on the far end of the serial link.
`timescale 1ns/10ps
`default_nettype none
module ssd_peer (
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_IN,
    input  wire logic        UNIT_ENABLE_IN,
    input  wire logic        CLOCK_IDLE_POLARITY_IN,
    input  wire logic        CLOCK_PHASE_IN,
    input  wire logic        MSB_FIRST_IN,
    input  wire logic [3:0]  WIDTH_CODE_IN,
    input  wire logic        SELECTED_IN,
    input  wire logic        OPEN_DRAIN_IN,
    input  wire logic        TRANSMIT_WRITE_IN,
    input  wire logic [15:0] TRANSMIT_DATA_IN,
    output logic      [15:0] RECEIVE_BUFFER_OUT,
    output logic             RECEIVE_DONE_OUT,
    output logic             TRANSFER_BUSY_FLAG_OUT,
    ssd_link_if.peer         link
);
    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic       sclk_prev_reg;
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            sync1_reg     <= 2'h3;
            sync2_reg     <= 2'h3;
            sclk_prev_reg <= ssd_pkg::LINE_IDLE;
        end else begin
            sync1_reg     <= {link.sclk, link.mosi};
            sync2_reg     <= sync1_reg;
            sclk_prev_reg <= sync2_reg[1];
        end
    end

    // ------------------------------------------------------------------
    // Slave transfer
    // ------------------------------------------------------------------
    ssd_pkg::ssd_state_t state_reg;
    logic [15:0] sr_reg;
    logic [15:0] tb_reg;
    logic        tb_full_reg;
    logic [3:0]  bits_reg;
    logic        dout_reg;
    logic        miso_o_reg;
    logic        miso_oe_reg;

    wire         en      = UNIT_ENABLE_IN;
    wire [3:0]   top     = ssd_pkg::ssd_top(WIDTH_CODE_IN);
    wire         run     = state_reg == ssd_pkg::ST_RUN;
    wire         edge_s  = en & (sync2_reg[1] ^ sclk_prev_reg);
    wire         lead    = edge_s & (sclk_prev_reg == CLOCK_IDLE_POLARITY_IN);
    wire         trail   = edge_s & (sclk_prev_reg != CLOCK_IDLE_POLARITY_IN);
    wire         latch   = CLOCK_PHASE_IN ? trail : lead;
    wire         shift   = run & (CLOCK_PHASE_IN ? lead : trail);
    wire         load    = en & ~run & tb_full_reg & ~latch;
    wire         done    = latch & (bits_reg == top);
    wire [15:0]  sr_in   = ssd_pkg::ssd_shift_in(sr_reg, sync2_reg[0], MSB_FIRST_IN, top);
    wire         miso_v  = SELECTED_IN ? dout_reg : 1'h1;
    wire         miso_oe = en & SELECTED_IN & (~OPEN_DRAIN_IN | ~dout_reg);
    wire ssd_pkg::ssd_state_t state_next = (~en | done) ? ssd_pkg::ST_IDLE :
                                           (load | latch) ? ssd_pkg::ST_RUN : state_reg;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            state_reg              <= ssd_pkg::ST_IDLE;
            sr_reg                 <= ssd_pkg::DATA_RESET;
            tb_reg                 <= ssd_pkg::DATA_RESET;
            tb_full_reg            <= 1'h0;
            bits_reg               <= ssd_pkg::BITS_RESET;
            dout_reg               <= ssd_pkg::LINE_IDLE;
            RECEIVE_BUFFER_OUT     <= ssd_pkg::DATA_RESET;
            RECEIVE_DONE_OUT       <= 1'h0;
            TRANSFER_BUSY_FLAG_OUT <= 1'h0;
            miso_o_reg             <= ssd_pkg::LINE_IDLE;
            miso_oe_reg            <= 1'h0;
        end else begin
            state_reg              <= state_next;
            sr_reg                 <= load ? tb_reg : (latch ? sr_in : sr_reg);
            tb_reg                 <= TRANSMIT_WRITE_IN ? TRANSMIT_DATA_IN : tb_reg;
            tb_full_reg            <= TRANSMIT_WRITE_IN | (tb_full_reg & ~load);
            bits_reg               <= (~en | done) ? ssd_pkg::BITS_RESET :
                                      (latch ? bits_reg + 4'h1 : bits_reg);
            dout_reg               <= load ? ssd_pkg::ssd_out_bit(tb_reg, MSB_FIRST_IN, top) :
                                      (shift ? ssd_pkg::ssd_out_bit(sr_reg, MSB_FIRST_IN, top)
                                             : dout_reg);
            RECEIVE_BUFFER_OUT     <= done ? sr_in : RECEIVE_BUFFER_OUT;
            RECEIVE_DONE_OUT       <= done;
            TRANSFER_BUSY_FLAG_OUT <= state_next == ssd_pkg::ST_RUN;
            miso_o_reg             <= miso_v;
            miso_oe_reg            <= miso_oe;
        end
    end

    // The peer never owns the clock or the master data line.
    assign link.peer_sclk_o   = 1'h1;
    assign link.peer_sclk_oe  = 1'h0;
    assign link.peer_mosi_o   = 1'h1;
    assign link.peer_mosi_oe  = 1'h0;
    assign link.peer_miso_o   = miso_o_reg;
    assign link.peer_miso_oe  = miso_oe_reg;
endmodule : ssd_peer
`default_nettype wire

// [verilog/ssd_unit.sv]
// Full-duplex synchronous serial shift unit, master or slave, with its pin control.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Only master drives shift clock pin.
// - Slaves keep clock pin as input.
// - Exactly one unit selected as master.
// - Master drives data-out line, slave return line.
// - Only selected slave drives return line.
// - Open-drain slaves send ones when unselected.
// - Enabled master idles clock, holds data level.
// - Transmit write loads shift register, bit at tick.
// - Shift on one edge, sample on other.
// - After width pulses, copy buffer, set flag.
// - Slave outputs first bit on load immediately.
// - Every transfer transmits and receives together.
// - Disabled unit holds alternate outputs at one.
// - Enabling idle-low drives clock pin low.
// - Software orders clock pin setup steps.
// - Role handover toggles mode and directions.
// - Shift path same for both bit orders.
// - Phase picks shift edge, polarity idle level.
// - Width 2 to 16, data right aligned.
// - Busy: master next tick, slave immediately.
module ssd_unit (
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_IN,
    input  wire logic        MASTER_SELECT_IN,
    input  wire logic        UNIT_ENABLE_IN,
    input  wire logic        CLOCK_IDLE_POLARITY_IN,
    input  wire logic        CLOCK_PHASE_IN,
    input  wire logic        MSB_FIRST_IN,
    input  wire logic [3:0]  WIDTH_CODE_IN,
    input  wire logic [15:0] BAUD_RELOAD_IN,
    input  wire logic        TRANSMIT_WRITE_IN,
    input  wire logic [15:0] TRANSMIT_DATA_IN,
    input  wire logic        RECEIVE_FLAG_CLEAR_IN,
    input  wire logic        CLOCK_PIN_OUTPUT_LATCH_IN,
    input  wire logic        CLOCK_PIN_DIRECTION_IN,
    input  wire logic        MOSI_PIN_LATCH_IN,
    input  wire logic        MOSI_PIN_DIRECTION_IN,
    input  wire logic        MISO_PIN_LATCH_IN,
    input  wire logic        MISO_PIN_DIRECTION_IN,
    input  wire logic        MISO_OPEN_DRAIN_IN,
    output logic      [15:0] RECEIVE_BUFFER_OUT,
    output logic             RECEIVE_IRQ_FLAG_OUT,
    output logic             TRANSFER_BUSY_FLAG_OUT,
    output logic             TRANSMIT_EMPTY_OUT,
    ssd_link_if.dev          link
);
    // ------------------------------------------------------------------
    // Link input synchronisers
    // ------------------------------------------------------------------
    // Bit 2 is the clock line, bit 1 master-out, bit 0 master-in.
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       sclk_prev_reg;
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            sync1_reg     <= ssd_pkg::SYNC_RESET;
            sync2_reg     <= ssd_pkg::SYNC_RESET;
            sclk_prev_reg <= ssd_pkg::LINE_IDLE;
        end else begin
            sync1_reg     <= {link.sclk, link.mosi, link.miso};
            sync2_reg     <= sync1_reg;
            sclk_prev_reg <= sync2_reg[2];
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ssd_pkg::ssd_state_t state_reg;
    logic [15:0] baud_reg;
    logic [5:0]  step_reg;
    logic [3:0]  bits_reg;
    logic [15:0] sr_reg;
    logic [15:0] tb_reg;
    logic        tb_full_reg;
    logic        dout_reg;
    logic        sclk_lvl_reg;
    logic        sclk_o_reg;
    logic        sclk_oe_reg;
    logic        mosi_o_reg;
    logic        mosi_oe_reg;
    logic        miso_o_reg;
    logic        miso_oe_reg;

    // ------------------------------------------------------------------
    // Master timing
    // ------------------------------------------------------------------
    // A master frame runs steps 0 to 2*bits; each step is one baud underflow.
    wire        en       = UNIT_ENABLE_IN;
    wire        is_m     = en & MASTER_SELECT_IN;
    wire        is_s     = en & ~MASTER_SELECT_IN;
    wire [3:0]  top      = ssd_pkg::ssd_top(WIDTH_CODE_IN);
    wire        run      = state_reg == ssd_pkg::ST_RUN;
    wire [5:0]  last     = {1'h0, top, 1'h0} + 6'h02;
    wire        tick     = is_m & run & (baud_reg == ssd_pkg::BAUD_ZERO);
    wire        m_shift  = tick & ~step_reg[0] & (step_reg < last);
    wire        m_latch  = tick & step_reg[0];
    wire        m_toggle = tick & (CLOCK_PHASE_IN ? (step_reg < last) :
                                   (step_reg != ssd_pkg::STEP_RESET));
    wire        m_start  = tick & (step_reg == ssd_pkg::STEP_RESET);
    wire        m_end    = tick & (step_reg == last);
    wire        m_load   = is_m & ~run & tb_full_reg;

    // ------------------------------------------------------------------
    // Slave edge decoding
    // ------------------------------------------------------------------
    // Edges are seen only while enabled, so a disabled unit stays still.
    wire        sclk_edge = is_s & (sync2_reg[2] ^ sclk_prev_reg);
    wire        lead      = sclk_edge & (sclk_prev_reg == CLOCK_IDLE_POLARITY_IN);
    wire        trail     = sclk_edge & (sclk_prev_reg != CLOCK_IDLE_POLARITY_IN);
    wire        s_latch   = CLOCK_PHASE_IN ? trail : lead;
    wire        s_shift   = run & (CLOCK_PHASE_IN ? lead : trail);
    wire        s_load    = is_s & ~run & tb_full_reg & ~s_latch;
    wire        s_start   = s_load | (s_latch & ~run);

    // ------------------------------------------------------------------
    // Shared shift path
    // ------------------------------------------------------------------
    // Both orders use the same path; only the tapped end changes.
    wire        load     = m_load | s_load;
    wire        latch_ev = m_latch | s_latch;
    wire        shift_ev = m_shift | s_shift;
    wire        rx_bit   = MASTER_SELECT_IN ? sync2_reg[0] : sync2_reg[1];
    wire [15:0] sr_in    = ssd_pkg::ssd_shift_in(sr_reg, rx_bit, MSB_FIRST_IN, top);
    wire        done     = latch_ev & (bits_reg == top);
    wire        s_stop   = is_s & done;
    wire        busy_set = m_start | s_start;
    wire        busy_clr = ~en | m_end | s_stop;

    wire ssd_pkg::ssd_state_t state_next = busy_clr ? ssd_pkg::ST_IDLE :
                                           (load | s_start) ? ssd_pkg::ST_RUN : state_reg;
    wire [15:0] baud_next = (~run | tick) ? BAUD_RELOAD_IN : baud_reg - 16'h0001;
    wire [5:0]  step_next = (~en | load) ? ssd_pkg::STEP_RESET :
                            (tick ? step_reg + 6'h01 : step_reg);
    wire [3:0]  bits_next = (~en | done | load) ? ssd_pkg::BITS_RESET :
                            (latch_ev ? bits_reg + 4'h1 : bits_reg);
    wire [15:0] sr_next   = load ? tb_reg : (latch_ev ? sr_in : sr_reg);
    wire        tb_bit    = ssd_pkg::ssd_out_bit(tb_reg, MSB_FIRST_IN, top);
    wire        sr_bit    = ssd_pkg::ssd_out_bit(sr_reg, MSB_FIRST_IN, top);
    wire        dout_next = s_load ? tb_bit : (shift_ev ? sr_bit : dout_reg);
    wire        lvl_next  = ~run ? CLOCK_IDLE_POLARITY_IN :
                            (m_toggle ? ~sclk_lvl_reg : sclk_lvl_reg);
    // A new frame that completes as software clears keeps the flag set.
    wire        irq_next  = done | (RECEIVE_IRQ_FLAG_OUT & ~RECEIVE_FLAG_CLEAR_IN);
    wire        busy_next = busy_set | (TRANSFER_BUSY_FLAG_OUT & ~busy_clr);

    // ------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------
    // Unused alternate lines sit at one so the port latch keeps control.
    wire        alt_sclk = is_m ? sclk_lvl_reg : 1'h1;
    wire        alt_mosi = is_m ? dout_reg : 1'h1;
    wire        alt_miso = is_s ? dout_reg : 1'h1;
    wire        miso_v   = alt_miso & MISO_PIN_LATCH_IN;
    // Open drain only sinks; a one is left to the pull-up.
    wire        miso_oe  = MISO_PIN_DIRECTION_IN & ~MASTER_SELECT_IN &
                           (~MISO_OPEN_DRAIN_IN | ~miso_v);
    wire        sclk_oe  = CLOCK_PIN_DIRECTION_IN & MASTER_SELECT_IN;
    wire        mosi_oe  = MOSI_PIN_DIRECTION_IN & MASTER_SELECT_IN;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            state_reg              <= ssd_pkg::ST_IDLE;
            baud_reg               <= ssd_pkg::BAUD_ZERO;
            step_reg               <= ssd_pkg::STEP_RESET;
            bits_reg               <= ssd_pkg::BITS_RESET;
            sr_reg                 <= ssd_pkg::DATA_RESET;
            tb_reg                 <= ssd_pkg::DATA_RESET;
            tb_full_reg            <= 1'h0;
            dout_reg               <= ssd_pkg::LINE_IDLE;
            sclk_lvl_reg           <= ssd_pkg::LINE_IDLE;
            RECEIVE_BUFFER_OUT     <= ssd_pkg::DATA_RESET;
            RECEIVE_IRQ_FLAG_OUT   <= 1'h0;
            TRANSFER_BUSY_FLAG_OUT <= 1'h0;
            TRANSMIT_EMPTY_OUT     <= 1'h1;
        end else begin
            state_reg              <= state_next;
            baud_reg               <= baud_next;
            step_reg               <= step_next;
            bits_reg               <= bits_next;
            sr_reg                 <= sr_next;
            tb_reg                 <= TRANSMIT_WRITE_IN ? TRANSMIT_DATA_IN : tb_reg;
            tb_full_reg            <= TRANSMIT_WRITE_IN | (tb_full_reg & ~load);
            dout_reg               <= dout_next;
            sclk_lvl_reg           <= lvl_next;
            RECEIVE_BUFFER_OUT     <= done ? sr_in : RECEIVE_BUFFER_OUT;
            RECEIVE_IRQ_FLAG_OUT   <= irq_next;
            TRANSFER_BUSY_FLAG_OUT <= busy_next;
            TRANSMIT_EMPTY_OUT     <= ~(TRANSMIT_WRITE_IN | (tb_full_reg & ~load));
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            sclk_o_reg  <= ssd_pkg::LINE_IDLE;
            sclk_oe_reg <= 1'h0;
            mosi_o_reg  <= ssd_pkg::LINE_IDLE;
            mosi_oe_reg <= 1'h0;
            miso_o_reg  <= ssd_pkg::LINE_IDLE;
            miso_oe_reg <= 1'h0;
        end else begin
            sclk_o_reg  <= alt_sclk & CLOCK_PIN_OUTPUT_LATCH_IN;
            sclk_oe_reg <= sclk_oe;
            mosi_o_reg  <= alt_mosi & MOSI_PIN_LATCH_IN;
            mosi_oe_reg <= mosi_oe;
            miso_o_reg  <= miso_v;
            miso_oe_reg <= miso_oe;
        end
    end

    assign link.dev_sclk_o  = sclk_o_reg;
    assign link.dev_sclk_oe = sclk_oe_reg;
    assign link.dev_mosi_o  = mosi_o_reg;
    assign link.dev_mosi_oe = mosi_oe_reg;
    assign link.dev_miso_o  = miso_o_reg;
    assign link.dev_miso_oe = miso_oe_reg;
endmodule : ssd_unit
`default_nettype wire

// [verification/ssd_link_assertions.sv]
// Checker for the link wires between the unit and its slave peer.
`timescale 1ns/10ps
`default_nettype none
module ssd_link_assertions (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic dev_sclk_o,
    input wire logic dev_sclk_oe,
    input wire logic dev_mosi_o,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic peer_sclk_oe,
    input wire logic peer_mosi_oe,
    input wire logic peer_miso_oe,
    input wire logic sclk
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Span checks assume the bench reload of 7, so one tick is 8 cycles.
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    property p_peer_no_sclk; !peer_sclk_oe; endproperty
    a_peer_no_sclk: assert property (p_peer_no_sclk) else $error("peer drives clock");
    property p_peer_no_mosi; !peer_mosi_oe; endproperty
    a_peer_no_mosi: assert property (p_peer_no_mosi) else $error("peer drives mosi");
    property p_master_no_miso; dev_sclk_oe || dev_mosi_oe |-> !dev_miso_oe; endproperty
    a_master_no_miso: assert property (p_master_no_miso) else $error("master on miso");
    property p_idle_high; !dev_sclk_oe |-> sclk; endproperty
    a_idle_high: assert property (p_idle_high) else $error("clock line not pulled up");
    property p_sclk_follows; dev_sclk_oe |-> sclk == dev_sclk_o; endproperty
    a_sclk_follows: assert property (p_sclk_follows) else $error("clock line mismatch");
    property p_release; $fell(RST_IN) |-> !dev_sclk_oe && !peer_miso_oe && dev_mosi_o; endproperty
    a_release: assert property (p_release) else $error("pins not idle after reset");
    property p_half_bit;
        $changed(dev_sclk_o) && dev_sclk_oe && $past(dev_sclk_oe) |=> $stable(dev_sclk_o)[*6];
    endproperty
    a_half_bit: assert property (p_half_bit) else $error("clock half period short");
    property p_bit_time;
        $changed(dev_mosi_o) && dev_mosi_oe && $past(dev_mosi_oe) |=> $stable(dev_mosi_o)[*8];
    endproperty
    a_bit_time: assert property (p_bit_time) else $error("mosi bit too short");
endmodule : ssd_link_assertions
`default_nettype wire

// [verification/sync_serial_full_duplex_bench.sv]
// Bench: the unit as master exchanging frames with the slave peer.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_full_duplex_bench;
    logic        clk = 1'h0, rst = 1'h1, ms = 1'h1, en = 1'h0, pol = 1'h0, ph = 1'h0;
    logic        msb = 1'h1, tw = 1'h0, rfc = 1'h0, clat = 1'h1, cdir = 1'h1, mdir = 1'h1;
    logic        sel = 1'h1, pod = 1'h0, rod = 1'h0;
    logic [3:0]  wc = 4'hf;
    logic [15:0] td = 16'h0000, ptd = 16'h0000, rx, prx;
    logic        irq, busy, pbusy, tbe, pdone;
    int          n_mismatch = 0, checks = 0, n_pdone = 0;
    ssd_link_if  ssd_link_if_i ();
    wire         sclk_pin = ssd_link_if_i.sclk;
    wire         mosi_pin = ssd_link_if_i.mosi;
    wire         miso_pin = ssd_link_if_i.miso;
    always #5 clk = ~clk;
    // The peer's done flag stands for one cycle only, so every pulse is counted here.
    always @(posedge clk) if (pdone === 1'h1) n_pdone++;
    ssd_unit ssd_unit_i (.CLOCK_IN(clk), .RST_IN(rst), .MASTER_SELECT_IN(ms), .UNIT_ENABLE_IN(en),
        .CLOCK_IDLE_POLARITY_IN(pol), .CLOCK_PHASE_IN(ph), .MSB_FIRST_IN(msb), .WIDTH_CODE_IN(wc),
        .BAUD_RELOAD_IN(16'h0007), .TRANSMIT_WRITE_IN(tw), .TRANSMIT_DATA_IN(td),
        .RECEIVE_FLAG_CLEAR_IN(rfc), .CLOCK_PIN_OUTPUT_LATCH_IN(clat), .CLOCK_PIN_DIRECTION_IN(cdir),
        .MOSI_PIN_LATCH_IN(1'h1), .MOSI_PIN_DIRECTION_IN(mdir), .MISO_PIN_LATCH_IN(1'h1),
        .MISO_PIN_DIRECTION_IN(1'h1), .MISO_OPEN_DRAIN_IN(rod), .RECEIVE_BUFFER_OUT(rx),
        .RECEIVE_IRQ_FLAG_OUT(irq), .TRANSFER_BUSY_FLAG_OUT(busy), .TRANSMIT_EMPTY_OUT(tbe),
        .link(ssd_link_if_i.dev));
    ssd_peer ssd_peer_i (.CLOCK_IN(clk), .RST_IN(rst), .UNIT_ENABLE_IN(en),
        .CLOCK_IDLE_POLARITY_IN(pol), .CLOCK_PHASE_IN(ph), .MSB_FIRST_IN(msb), .WIDTH_CODE_IN(wc),
        .SELECTED_IN(sel), .OPEN_DRAIN_IN(pod), .TRANSMIT_WRITE_IN(tw), .TRANSMIT_DATA_IN(ptd),
        .RECEIVE_BUFFER_OUT(prx), .RECEIVE_DONE_OUT(pdone), .TRANSFER_BUSY_FLAG_OUT(pbusy),
        .link(ssd_link_if_i.peer));
    ssd_link_assertions ssd_link_assertions_i (.CLOCK_IN(clk), .RST_IN(rst),
        .dev_sclk_o(ssd_link_if_i.dev_sclk_o), .dev_sclk_oe(ssd_link_if_i.dev_sclk_oe),
        .dev_mosi_o(ssd_link_if_i.dev_mosi_o), .dev_mosi_oe(ssd_link_if_i.dev_mosi_oe),
        .dev_miso_oe(ssd_link_if_i.dev_miso_oe), .peer_sclk_oe(ssd_link_if_i.peer_sclk_oe),
        .peer_mosi_oe(ssd_link_if_i.peer_mosi_oe), .peer_miso_oe(ssd_link_if_i.peer_miso_oe),
        .sclk(sclk_pin));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic end_of_test;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Steps are spaced by a full tick so no pin edge looks like a short clock pulse.
    task automatic setup(input logic p, input logic h, input logic m, input logic [3:0] w);
        en = 1'h0;
        cyc(8);
        pol = p;
        ph = h;
        msb = m;
        wc = w;
        clat = p;
        cyc(8);
        en = 1'h1;
        cyc(8);
        clat = 1'h1;
        cyc(8);
        chk({15'h0000, sclk_pin}, {15'h0000, p});
    endtask : setup
    task automatic xfer(input logic [15:0] d, input logic [15:0] p);
        logic [15:0] m;
        int          n0;
        m = 16'hffff >> (4'hf - wc);
        n0 = n_pdone;
        td = d;
        ptd = p;
        tw = 1'h1;
        rfc = 1'h1;
        cyc(1);
        tw = 1'h0;
        rfc = 1'h0;
        chk({15'h0000, tbe}, 16'h0000);
        cyc(6);
        chk({14'h0000, pbusy, busy}, 16'h0002);
        chk({15'h0000, tbe}, 16'h0001);
        if (sel) chk({15'h0000, miso_pin}, {15'h0000, msb ? p[wc] : p[0]});
        for (int i = 0; i < 800 && irq !== 1'h1; i++) cyc(1);
        chk({14'h0000, irq, busy}, 16'h0003);
        for (int i = 0; i < 100 && busy !== 1'h0; i++) cyc(1);
        cyc(8);
        chk(rx & m, sel ? p & m : m);
        chk(prx & m, d & m);
        chk(16'(n_pdone - n0), 16'h0001);
        $display("frame test done, %0d bits", wc + 1);
    endtask : xfer
    task automatic t_roles;
        // Enabling idle-low with the latch already at one pulls the clock pin low at once.
        en = 1'h1;
        cyc(1);
        chk({15'h0000, sclk_pin}, 16'h0000);
        cyc(8);
        en = 1'h0;
        cyc(8);
        ms = 1'h0;
        cdir = 1'h0;
        mdir = 1'h0;
        clat = 1'h0;
        en = 1'h1;
        cyc(8);
        chk({14'h0000, sclk_pin, mosi_pin}, 16'h0003);
        en = 1'h0;
        ms = 1'h1;
        cdir = 1'h1;
        mdir = 1'h1;
        $display("roles test done");
    endtask : t_roles
    task automatic t_select;
        setup(1'h0, 1'h1, 1'h0, 4'hf);
        sel = 1'h0;
        xfer(16'h1234, 16'h0000);
        pod = 1'h1;
        rod = 1'h1;
        sel = 1'h1;
        xfer(16'h5678, 16'h00f0);
        $display("select test done");
    endtask : t_select
    task automatic t_disabled;
        en = 1'h0;
        cyc(8);
        tw = 1'h1;
        td = 16'h00ff;
        cyc(1);
        tw = 1'h0;
        cyc(300);
        chk({rx[14:0], busy}, {15'h00f0, 1'h0});
        chk({15'h0000, sclk_pin}, 16'h0001);
        chk({15'h0000, tbe}, 16'h0000);
        $display("disabled test done");
    endtask : t_disabled
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(8);
        rst = 1'h0;
        cyc(3);
        chk({14'h0000, sclk_pin, mosi_pin}, 16'h0003);
        t_roles();
        for (int k = 0; k < 8; k++) begin
            setup(k[0], k[1], k[2], 4'hf - 4'(k * 2));
            xfer(16'h9a3c ^ 16'(k * 16'h1111), 16'h3c5a ^ 16'(k));
        end
        t_select();
        t_disabled();
        end_of_test();
    end
    initial begin
        #200us;
        n_mismatch++;
        end_of_test();
    end
endmodule : sync_serial_full_duplex_bench
`default_nettype wire
